/* pkg/msp_pkg.sv */
// shared constants, types and register map of the section protection block
package msp_pkg;
  localparam int NW = 14;
  localparam int APS_W = 13;
  localparam logic [11:0] K1_IDX = 12'h43B;
  localparam logic [11:0] K2_IDX = 12'h43E;
  localparam logic [1:0] FILT_N = 2'h3;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic ARCH_1N = 1'b1;
  localparam int CLK_HZ = 50_000_000;
  localparam int WTR_UNIT_S = 1;
  localparam int SEC_CYCLES_DEF = WTR_UNIT_S * CLK_HZ;
  localparam logic [9:0] WTR_MAX_S = 10'h2D0;
  localparam logic [9:0] WTR_RST = 10'h12C;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WTR = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_SWCNT = 8'h10;
  localparam logic [7:0] REG_SWDUR = 8'h14;
  localparam logic [7:0] REG_TXAPS = 8'h18;
  localparam int CTRL_DIR = 0;
  localparam int CTRL_SPARE = 1;
  localparam int CTRL_NULL = 2;
  localparam int CTRL_NULLCH = 4;
  localparam int CTRL_REPORT = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_01FF;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] NULL_NORMAL = 2'h0;
  localparam logic [1:0] NULL_ONES = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] REQ_LO = 4'hF;
  localparam logic [3:0] REQ_FS = 4'hE;
  localparam logic [3:0] REQ_SF = 4'hD;
  localparam logic [3:0] REQ_SD = 4'hB;
  localparam logic [3:0] REQ_MS = 4'h8;
  localparam logic [3:0] REQ_WTR = 4'h6;
  localparam logic [3:0] REQ_EXERCISE_CMD = 4'h4;
  localparam logic [3:0] REQ_RR = 4'h2;
  localparam logic [3:0] REQ_NR = 4'h0;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0, CMD_CLEAR = 3'h1, CMD_LOCKOUT = 3'h2,
    CMD_FORCED = 3'h3, CMD_MANUAL = 3'h4, CMD_EXERCISE_CMD = 3'h5
  } msp_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_SWITCHED = 3'b010, ST_RESTORE = 3'b100
  } msp_state_t;
  typedef struct packed {
    logic [7:0] d;
    logic ck;
    logic fs;
  } msp_stream_t;
  typedef struct packed {
    logic [7:0] d;
    logic ck;
    logic fs;
    logic fail;
    logic degrade;
  } msp_line_t;
endpackage

/* hdl/msp_aps_filter.sv */
// switching channel extraction and three-frame persistence filter
`timescale 1ns/1ns
module msp_aps_filter
  import msp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic byte_edge,
  input wire logic fs,
  input wire logic [7:0] d,
  output logic [APS_W-1:0] aps_out
);
  logic [11:0] idx;
  logic [7:0] k1_q;
  logic [APS_W-1:0] last;
  logic [1:0] same_cnt;
  wire [11:0] next_idx = fs ? 12'h000 : idx + 12'h001;
  wire [APS_W-1:0] cand = {k1_q, d[7:3]};
  wire k1_here = byte_edge && next_idx == K1_IDX;
  wire k2_here = byte_edge && next_idx == K2_IDX;
  wire same = cand == last;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx <= 12'h000;
      k1_q <= 8'h00;
      last <= 13'h0000;
      same_cnt <= 2'h0;
      aps_out <= 13'h0000;
    end else begin
      if (byte_edge) idx <= next_idx;
      if (k1_here) k1_q <= d;
      if (k2_here) begin
        last <= cand;
        if (!same) same_cnt <= 2'h1;
        else if (same_cnt != FILT_N) same_cnt <= same_cnt + 2'h1;
        if (same && same_cnt == FILT_N - 2'h1) aps_out <= cand;
      end
    end
  end
endmodule

/* hdl/msp_top.sv */
// 1:n section protection: bridge/selector, trail termination and adaptation
// Summary of operation
// - up to fourteen working sections share one protection section
// - receive selection follows fail, degrade, operator commands and received channel
// - each working output is fed permanently from its normal input
// - protection output is unfed, extra traffic, or a bridged normal input
// - direction or restore-wait changes while idle leave traffic untouched
// - switching channel is 13 bits: whole first byte, top five of second
// - revertive; restore waits a configurable zero to twelve minutes
// - lockout, forced, manual, clear and exercise commands are accepted
// - unassigned protection output carries the null signal
// - null signal is a normal input, all ones, or a test pattern
// - on a switch extra traffic output goes all ones with fail raised
// - protection termination source passes data, clock and frame start unchanged
// - reported server fail is incoming fail gated by the report enable
// - trail fail always copies the incoming fail of the section that feeds each output
// - adaptation source inserts the switching channel into the outgoing stream
// - adaptation sink forwards stream and copies fail; degrade reaches only the extra traffic output
// - sink pulls the switching channel bits from each received frame
// - a new channel value is accepted after three identical frames
// - only the protection section sink extracts and filters the channel
`timescale 1ns/1ns
module msp_top
  import msp_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DEF
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input msp_line_t work_rx [NW],
  input msp_line_t prot_rx,
  input msp_stream_t norm_tx [NW],
  input msp_stream_t extra_tx,
  output msp_line_t norm_rx [NW],
  output msp_line_t extra_rx,
  output msp_stream_t work_tx [NW],
  output msp_stream_t prot_tx,
  output logic [NW-1:0] trail_fail_ind,
  output logic [NW-1:0] reported_server_fail,
  output logic [APS_W-1:0] rx_aps,
  output logic protocol_failure_alarm
);
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == REG_CTRL || a == REG_WTR || a == REG_CMD || a == REG_STATUS ||
           a == REG_SWCNT || a == REG_SWDUR || a == REG_TXAPS;
  endfunction

  function automatic logic ch_ok(input logic [3:0] ch);
    return ch != 4'h0 && ch <= 4'(NW);
  endfunction

  function automatic logic is_switch(input logic [3:0] req);
    return req == REQ_FS || req == REQ_SF || req == REQ_SD || req == REQ_MS || req == REQ_WTR;
  endfunction

  // input synchronisers, three stages each
  msp_line_t w1 [NW], w2 [NW], w3 [NW];
  msp_stream_t n1 [NW], n2 [NW], n3 [NW];
  msp_line_t p1, p2, p3;
  msp_stream_t e1, e2, e3;
  always_ff @(posedge aclk) begin
    w1 <= work_rx;
    w2 <= w1;
    w3 <= w2;
    n1 <= norm_tx;
    n2 <= n1;
    n3 <= n2;
    p1 <= prot_rx;
    p2 <= p1;
    p3 <= p2;
    e1 <= extra_tx;
    e2 <= e1;
    e3 <= e2;
  end

  // register file and bus state
  logic [31:0] ctrl;
  logic [9:0] wtr_set;
  msp_cmd_t cmd_code;
  logic [3:0] cmd_ch;
  logic aw_held, w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] sw_count, sw_dur;

  // control state
  msp_state_t state, next_state;
  logic [3:0] sel, act_req, next_sel;
  logic dir_eff;
  logic [9:0] wtr_eff, wtr_cnt;
  logic [31:0] sec_cnt;
  logic [3:0] loc_req, loc_ch, sf_ch, sd_ch;
  logic [APS_W-1:0] aps_acc;
  logic pk_lvl, tx_ck_q;
  logic [11:0] tx_idx;

  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire do_wr = aw_held && w_held && !bvalid;
  wire next_aw_held = do_wr ? 1'b0 : (aw_held || aw_take);
  wire next_w_held = do_wr ? 1'b0 : (w_held || w_take);
  wire next_bvalid = do_wr || (bvalid && !bready);
  wire ar_take = arvalid && arready;
  wire next_rvalid = ar_take || (rvalid && !rready);
  wire [31:0] wr_val = strb_merge(32'h0000_0000, w_data_q, w_strb_q);
  wire wr_ctrl = do_wr && aw_addr_q == REG_CTRL;
  wire wr_wtr = do_wr && aw_addr_q == REG_WTR;
  wire wr_cmd = do_wr && aw_addr_q == REG_CMD;
  wire [31:0] wtr_full = strb_merge({22'h00_0000, wtr_set}, w_data_q, w_strb_q);
  wire [9:0] wtr_wr = wtr_full[9:0];
  msp_cmd_t cmd_wr;
  assign cmd_wr = msp_cmd_t'(wr_val[2:0]);
  wire [3:0] cmd_ch_wr = wr_val[7:4];
  wire cmd_needs_ch = cmd_wr == CMD_FORCED || cmd_wr == CMD_MANUAL || cmd_wr == CMD_EXERCISE_CMD;
  wire cmd_valid = cmd_wr <= CMD_EXERCISE_CMD && (!cmd_needs_ch || ch_ok(cmd_ch_wr));

  wire spare_en = ctrl[CTRL_SPARE];
  wire [1:0] null_mode = ctrl[CTRL_NULL +: 2];
  wire [3:0] null_ch = ctrl[CTRL_NULLCH +: 4];
  wire report_en = ctrl[CTRL_REPORT];
  wire sec_tick = sec_cnt == 32'(SEC_CYCLES - 1);

  // received channel fields
  wire [3:0] rx_req = aps_acc[12:9];
  wire [3:0] rx_ch = aps_acc[8:5];
  wire [3:0] rx_bridge = aps_acc[4:1];
  wire far_wins = dir_eff && is_switch(rx_req) && rx_req > loc_req && ch_ok(rx_ch);
  wire [3:0] tx_req = far_wins ? REQ_RR : loc_req;
  wire [3:0] tx_ch = far_wins ? rx_ch : loc_ch;
  wire [APS_W-1:0] aps_tx = {tx_req, tx_ch, sel, ARCH_1N};
  wire wtr_want = (state == ST_RESTORE && wtr_cnt != 10'h000) ||
                  (state == ST_SWITCHED && (act_req == REQ_SF || act_req == REQ_SD));

  wire [31:0] status = {3'h0, rx_aps, 4'h0, protocol_failure_alarm, state, tx_req, sel};
  wire [31:0] rd_word =
    araddr == REG_CTRL ? ctrl :
    araddr == REG_WTR ? {22'h00_0000, wtr_set} :
    araddr == REG_CMD ? {24'h00_0000, cmd_ch, 1'b0, cmd_code} :
    araddr == REG_STATUS ? status :
    araddr == REG_SWCNT ? sw_count :
    araddr == REG_SWDUR ? sw_dur :
    araddr == REG_TXAPS ? {19'h0_0000, aps_tx} : 32'h0000_0000;

  // working sections: most urgent is the lowest numbered
  always_comb begin
    sf_ch = 4'h0;
    sd_ch = 4'h0;
    for (int i = NW - 1; i >= 0; i--) begin
      if (w3[i].fail) sf_ch = 4'(i + 1);
      if (w3[i].degrade) sd_ch = 4'(i + 1);
    end
  end

  // local request by priority
  always_comb begin
    loc_req = REQ_NR;
    loc_ch = 4'h0;
    if (cmd_code == CMD_LOCKOUT) begin
      loc_req = REQ_LO;
    end else if (cmd_code == CMD_FORCED) begin
      loc_req = REQ_FS;
      loc_ch = cmd_ch;
    end else if (p3.fail) begin
      loc_req = REQ_SF;
    end else if (sf_ch != 4'h0) begin
      loc_req = REQ_SF;
      loc_ch = sf_ch;
    end else if (sd_ch != 4'h0) begin
      loc_req = REQ_SD;
      loc_ch = sd_ch;
    end else if (cmd_code == CMD_MANUAL) begin
      loc_req = REQ_MS;
      loc_ch = cmd_ch;
    end else if (wtr_want) begin
      loc_req = REQ_WTR;
      loc_ch = sel;
    end else if (cmd_code == CMD_EXERCISE_CMD) begin
      loc_req = REQ_EXERCISE_CMD;
      loc_ch = cmd_ch;
    end
  end

  assign next_sel = far_wins ? rx_ch : (is_switch(loc_req) ? loc_ch : 4'h0);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (next_sel != 4'h0) next_state = ST_SWITCHED;
      end
      ST_SWITCHED: begin
        if (next_sel == 4'h0) next_state = ST_IDLE;
        else if (loc_req == REQ_WTR && !far_wins) next_state = ST_RESTORE;
      end
      ST_RESTORE: begin
        if (next_sel == 4'h0) next_state = ST_IDLE;
        else if (far_wins || loc_req != REQ_WTR) next_state = ST_SWITCHED;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // bus slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      bvalid <= next_bvalid;
      awready <= !next_aw_held && !next_bvalid;
      wready <= !next_w_held && !next_bvalid;
      arready <= !next_rvalid;
      rvalid <= next_rvalid;
      if (aw_take) aw_addr_q <= awaddr;
      if (w_take) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_wr) bresp <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      if (ar_take) begin
        rdata <= rd_word;
        rresp <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // registers, commands and monitors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RST;
      wtr_set <= WTR_RST;
      cmd_code <= CMD_NONE;
      cmd_ch <= 4'h0;
      sw_count <= 32'h0000_0000;
      sw_dur <= 32'h0000_0000;
      sec_cnt <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) ctrl <= strb_merge(ctrl, w_data_q, w_strb_q) & CTRL_MASK;
      if (wr_wtr) wtr_set <= wtr_wr > WTR_MAX_S ? WTR_MAX_S : wtr_wr;
      if (wr_cmd && cmd_valid && cmd_wr != CMD_NONE) begin
        cmd_code <= cmd_wr == CMD_CLEAR ? CMD_NONE : cmd_wr;
        cmd_ch <= cmd_wr == CMD_CLEAR ? 4'h0 : cmd_ch_wr;
      end
      sec_cnt <= sec_tick ? 32'h0000_0000 : sec_cnt + 32'h0000_0001;
      if (sel == 4'h0 && next_sel != 4'h0) sw_count <= sw_count + 32'h0000_0001;
      if (sel != 4'h0 && sec_tick) sw_dur <= sw_dur + 32'h0000_0001;
    end
  end

  // switching control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      sel <= 4'h0;
      act_req <= REQ_NR;
      dir_eff <= 1'b0;
      wtr_eff <= WTR_RST;
      wtr_cnt <= 10'h000;
      protocol_failure_alarm <= 1'b0;
      rx_aps <= 13'h0000;
    end else begin
      state <= next_state;
      sel <= next_sel;
      act_req <= tx_req;
      if (state == ST_IDLE && loc_req == REQ_NR && !far_wins) begin
        dir_eff <= ctrl[CTRL_DIR];
        wtr_eff <= wtr_set;
      end
      if (state != ST_RESTORE && next_state == ST_RESTORE) wtr_cnt <= wtr_eff;
      else if (state == ST_RESTORE && sec_tick && wtr_cnt != 10'h000) wtr_cnt <= wtr_cnt - 10'h001;
      protocol_failure_alarm <= aps_acc[0] != ARCH_1N ||
                                (dir_eff && is_switch(tx_req) && rx_bridge != tx_ch);
      rx_aps <= aps_acc;
    end
  end

  // protection receive: agreed clock level and byte edges
  wire p_edge = p2.ck && p3.ck && !pk_lvl;
  always_ff @(posedge aclk) begin
    if (!aresetn) pk_lvl <= 1'b0;
    else if (p2.ck == p3.ck) pk_lvl <= p3.ck;
  end

  // extraction only on the protection section sink
  msp_aps_filter i_msp_aps_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .byte_edge(p_edge),
    .fs(p3.fs),
    .d(p3.d),
    .aps_out(aps_acc)
  );

  // transmit protection source selection
  wire [3:0] sel_m1 = sel - 4'h1;
  wire [3:0] null_m1 = ch_ok(null_ch) ? null_ch - 4'h1 : 4'h0;
  wire [7:0] null_d = null_mode == NULL_NORMAL ? n3[null_m1].d :
                      null_mode == NULL_ONES ? ALL_ONES : tx_idx[7:0];
  wire msp_stream_t null_src = '{d: null_d, ck: n3[null_m1].ck, fs: n3[null_m1].fs};
  wire msp_stream_t tx_src = sel != 4'h0 ? n3[sel_m1] :
                             spare_en ? e3 : null_src;
  wire tx_edge = tx_src.ck && !tx_ck_q;
  wire [11:0] next_tx_idx = !tx_edge ? tx_idx : (tx_src.fs ? 12'h000 : tx_idx + 12'h001);
  wire [7:0] tx_d = next_tx_idx == K1_IDX ? aps_tx[12:5] :
                    next_tx_idx == K2_IDX ? {aps_tx[4:0], tx_src.d[2:0]} : tx_src.d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ck_q <= 1'b0;
      tx_idx <= 12'h000;
      prot_tx <= '0;
      extra_rx <= '0;
      for (int i = 0; i < NW; i++) begin
        work_tx[i] <= '0;
        norm_rx[i] <= '0;
      end
      trail_fail_ind <= '0;
      reported_server_fail <= '0;
    end else begin
      tx_ck_q <= tx_src.ck;
      tx_idx <= next_tx_idx;
      prot_tx <= '{d: tx_d, ck: tx_src.ck, fs: tx_src.fs};
      for (int i = 0; i < NW; i++) begin
        work_tx[i] <= n3[i];
        if (sel == 4'(i + 1)) begin
          norm_rx[i] <= '{d: p3.d, ck: p3.ck, fs: p3.fs, fail: p3.fail, degrade: 1'b0};
          trail_fail_ind[i] <= p3.fail;
          reported_server_fail[i] <= p3.fail && report_en;
        end else begin
          norm_rx[i] <= '{d: w3[i].d, ck: w3[i].ck, fs: w3[i].fs, fail: w3[i].fail,
                          degrade: 1'b0};
          trail_fail_ind[i] <= w3[i].fail;
          reported_server_fail[i] <= w3[i].fail && report_en;
        end
      end
      if (sel != 4'h0 || !spare_en) begin
        extra_rx <= '{d: ALL_ONES, ck: p3.ck, fs: p3.fs, fail: 1'b1, degrade: 1'b0};
      end else begin
        extra_rx <= '{d: p3.d, ck: p3.ck, fs: p3.fs, fail: p3.fail, degrade: p3.degrade};
      end
    end
  end
endmodule

/* bench/msp_monitor.sv */
// assertion checker for the section protection block
`timescale 1ns/1ns
module msp_monitor
  import msp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input msp_stream_t norm_tx [NW],
  input msp_stream_t work_tx [NW],
  input msp_line_t extra_rx,
  input wire logic [NW-1:0] trail_fail_ind,
  input wire logic [NW-1:0] reported_server_fail,
  input wire logic [APS_W-1:0] rx_aps
);
  logic [2:0] up;
  // cycles since reset release, so the pipeline holds only post-reset data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up <= 3'h0;
    end else if (up != 3'h7) begin
      up <= up + 3'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_work_first: assert property (up == 3'h7 |-> work_tx[0] == $past(norm_tx[0], 4))
    else $error("working output 0 not fed from its normal input");
  chk_work_last: assert property (up == 3'h7 |-> work_tx[NW-1] == $past(norm_tx[NW-1], 4))
    else $error("last working output not fed from its normal input");
  chk_extra_ones: assert property (extra_rx.fail |-> extra_rx.d == ALL_ONES)
    else $error("extra traffic output not all ones while failed");
  chk_report_gate: assert property ((reported_server_fail & ~(trail_fail_ind | $past(trail_fail_ind))) == '0)
    else $error("reported fail without incoming fail");
  chk_read_lat: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  chk_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  chk_write_lat: assert property (awvalid && awready && wvalid && wready |-> ##[2:3] bvalid)
    else $error("write answer late");
  chk_read_block: assert property (rvalid |-> !arready)
    else $error("read address taken while answer pending");
  chk_aps_steady: assert property ($changed(rx_aps) |=> $stable(rx_aps) [*8])
    else $error("switching channel changed without persistence");
  cover property (bvalid && bresp == RESP_SLVERR);
  cover property ($rose(extra_rx.fail));
  cover property ($changed(rx_aps));
endmodule
bind msp_top msp_monitor i_msp_monitor (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .norm_tx, .work_tx,
  .extra_rx, .trail_fail_ind, .reported_server_fail, .rx_aps);

/* bench/msp_far_end.sv */
// far-end section model: framed line streams and transmit capture
`timescale 1ns/1ns
module msp_far_end
  import msp_pkg::*;
(
  input wire logic aclk,
  input wire logic [NW-1:0] work_fail,
  input wire logic [NW-1:0] work_degrade,
  input wire logic prot_fail,
  input wire logic prot_degrade,
  input msp_stream_t prot_tx,
  output msp_line_t work_rx [NW],
  output msp_line_t prot_rx,
  output logic [7:0] tx_k2
);
  logic [7:0] d = 8'h00;
  logic ck = 1'b0;
  logic fs = 1'b0;
  logic ck_q = 1'b0;
  logic [11:0] tx_idx = 12'h000;
  assign prot_rx = '{d, ck, fs, prot_fail, prot_degrade};
  for (genvar i = 0; i < NW; i++) begin : g_work
    assign work_rx[i] = '{d, ck, fs, work_fail[i], work_degrade[i]};
  end
  // one frame; clock stands still between frames
  task automatic send_frame(input logic [APS_W-1:0] aps);
    #7;
    for (int i = 0; i <= int'(K2_IDX) + 4; i++) begin
      d = (i == int'(K1_IDX)) ? aps[12:5] : (i == int'(K2_IDX)) ? {aps[4:0], 3'h5} : 8'(i);
      fs = (i == 0);
      #80 ck = 1'b1;
      #80 ck = 1'b0;
    end
    d = ~d;
    fs = 1'b0;
  endtask
  // capture second switching byte of the protection transmit stream
  always @(posedge aclk) begin
    ck_q <= prot_tx.ck;
    if (prot_tx.ck && !ck_q) begin
      tx_idx <= prot_tx.fs ? 12'h001 : tx_idx + 12'h001;
      if (!prot_tx.fs && tx_idx == K2_IDX) begin
        tx_k2 <= prot_tx.d;
      end
    end
  end
endmodule

/* bench/tb_top.sv */
// self-checking bench for the section protection block
`timescale 1ns/1ns
module tb_top
  import msp_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [NW-1:0] work_fail = '0;
  logic [NW-1:0] work_degrade = '0;
  logic [3:0] wstrb = 4'hF;
  logic prot_fail = 1'b0, prot_degrade = 1'b0, protocol_failure_alarm;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  msp_line_t work_rx [NW];
  msp_line_t norm_rx [NW];
  msp_line_t prot_rx, extra_rx;
  msp_stream_t norm_tx [NW];
  msp_stream_t work_tx [NW];
  msp_stream_t extra_tx, prot_tx;
  logic [NW-1:0] trail_fail_ind, reported_server_fail;
  logic [APS_W-1:0] rx_aps;
  logic [7:0] tx_k2;
  int errors = 0;
  int tests_run = 0;
  always #10 aclk = ~aclk;
  for (genvar i = 0; i < NW; i++) begin : g_norm
    assign norm_tx[i] = '{prot_rx.d ^ 8'(i), prot_rx.ck, prot_rx.fs};
  end
  assign extra_tx = '{~prot_rx.d, prot_rx.ck, prot_rx.fs};
  msp_top #(.SEC_CYCLES(20)) i_msp_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .work_rx, .prot_rx, .norm_tx, .extra_tx, .norm_rx,
    .extra_rx, .work_tx, .prot_tx, .trail_fail_ind, .reported_server_fail, .rx_aps,
    .protocol_failure_alarm);
  msp_far_end i_msp_far_end (.aclk, .work_fail, .work_degrade, .prot_fail, .prot_degrade,
    .prot_tx, .work_rx, .prot_rx, .tx_k2);
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timed_out();
    errors++;
    $display("CHECK FAILED at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
    final_report();
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 200);
    if (n >= 200) timed_out();
    check_resp(bresp, er);
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 200);
    if (n >= 200) timed_out();
    check_word(rdata & m, v);
    check_resp(rresp, er);
    rready <= 1'b0;
  endtask
  task automatic wait_extra(input logic v);
    int n;
    n = 0;
    while (extra_rx.fail !== v && n < 50) begin
      @(posedge aclk);
      n++;
    end
    check_word({31'h0000_0000, extra_rx.fail}, {31'h0000_0000, v});
  endtask
  task automatic test_regs();
    axi_read(REG_CTRL, CTRL_MASK, CTRL_RST, RESP_OKAY);
    axi_read(REG_WTR, 32'h0000_03FF, {22'h00_0000, WTR_RST}, RESP_OKAY);
    axi_read(REG_STATUS, 32'h0000_0700, 32'h0000_0100, RESP_OKAY);
    axi_write(REG_WTR, 32'h0000_03FF, RESP_OKAY);
    axi_read(REG_WTR, 32'h0000_03FF, {22'h00_0000, WTR_MAX_S}, RESP_OKAY);
    wstrb <= 4'h1;
    axi_write(REG_WTR, 32'h0000_0000, RESP_OKAY);
    axi_read(REG_WTR, 32'h0000_03FF, 32'h0000_0200, RESP_OKAY);
    wstrb <= 4'hF;
    axi_write(REG_STATUS, 32'h0000_0000, RESP_OKAY);
    axi_read(REG_STATUS, 32'h0000_0700, 32'h0000_0100, RESP_OKAY);
    axi_write(8'h1C, 32'h0000_0001, RESP_SLVERR);
    axi_read(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000, RESP_SLVERR);
    axi_write(REG_WTR, 32'h0000_0000, RESP_OKAY);
  endtask
  task automatic test_aps();
    i_msp_far_end.send_frame(13'h0123);
    i_msp_far_end.send_frame(13'h0123);
    check_word(32'(rx_aps), 32'h0000_0000);
    i_msp_far_end.send_frame(13'h0123);
    check_word(32'(rx_aps), 32'h0000_0123);
    check_word({31'h0000_0000, protocol_failure_alarm}, 32'h0000_0000);
    i_msp_far_end.send_frame(13'h1ABC);
    i_msp_far_end.send_frame(13'h1ABC);
    i_msp_far_end.send_frame(13'h0F0F);
    i_msp_far_end.send_frame(13'h0F0F);
    check_word(32'(rx_aps), 32'h0000_0123);
    i_msp_far_end.send_frame(13'h0F0F);
    check_word(32'(rx_aps), 32'h0000_0F0F);
    axi_read(REG_STATUS, 32'h1FFF_0000, 32'h0F0F_0000, RESP_OKAY);
    check_word({28'h000_0000, tx_k2[3:0]}, 32'h0000_000D);
  endtask
  task automatic test_cmds();
    axi_write(REG_CTRL, 32'h0000_0002, RESP_OKAY);
    wait_extra(1'b0);
    axi_write(REG_CMD, 32'h0000_0035, RESP_OKAY);
    axi_read(REG_CMD, 32'h0000_00FF, 32'h0000_0035, RESP_OKAY);
    wait_extra(1'b0);
    axi_write(REG_CMD, 32'h0000_0034, RESP_OKAY);
    axi_read(REG_CMD, 32'h0000_00FF, 32'h0000_0034, RESP_OKAY);
    wait_extra(1'b1);
    check_word({24'h00_0000, extra_rx.d}, 32'h0000_00FF);
    axi_read(REG_STATUS, 32'h0000_070F, 32'h0000_0203, RESP_OKAY);
    axi_write(REG_CMD, 32'h0000_00E3, RESP_OKAY);
    axi_read(REG_CMD, 32'h0000_00FF, 32'h0000_00E3, RESP_OKAY);
    axi_read(REG_STATUS, 32'h0000_070F, 32'h0000_020E, RESP_OKAY);
    axi_write(REG_CMD, 32'h0000_0002, RESP_OKAY);
    axi_read(REG_CMD, 32'h0000_0007, 32'h0000_0002, RESP_OKAY);
    work_fail <= 14'h0002;
    repeat (6) @(posedge aclk);
    check_word({18'h0_0000, trail_fail_ind}, 32'h0000_0002);
    check_word({31'h0000_0000, norm_rx[1].fail}, 32'h0000_0001);
    check_word({18'h0_0000, reported_server_fail}, 32'h0000_0000);
    axi_write(REG_CTRL, 32'h0000_0102, RESP_OKAY);
    repeat (6) @(posedge aclk);
    check_word({18'h0_0000, reported_server_fail}, 32'h0000_0002);
    work_fail <= 14'h0000;
    repeat (6) @(posedge aclk);
    check_word({18'h0_0000, trail_fail_ind}, 32'h0000_0000);
    axi_write(REG_CMD, 32'h0000_0001, RESP_OKAY);
    wait_extra(1'b0);
    work_degrade <= 14'h0010;
    wait_extra(1'b1);
    work_degrade <= 14'h0000;
    wait_extra(1'b0);
    prot_degrade <= 1'b1;
    repeat (6) @(posedge aclk);
    check_word({31'h0000_0000, extra_rx.degrade}, 32'h0000_0001);
    prot_degrade <= 1'b0;
    axi_write(REG_CTRL, 32'h0000_0004, RESP_OKAY);
    repeat (6) @(posedge aclk);
    check_word({24'h00_0000, prot_tx.d}, 32'h0000_00FF);
    prot_fail <= 1'b1;
    repeat (6) @(posedge aclk);
    axi_read(REG_TXAPS, 32'h0000_1E00, 32'h0000_1A00, RESP_OKAY);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_aps();
    test_cmds();
    final_report();
  end
  initial begin
    repeat (95000) @(posedge aclk);
    timed_out();
  end
endmodule
